/* File: logic/fault_tolerant_can_transceiver_ctrl.sv */
`timescale 1ns/1ps
module fault_tolerant_can_transceiver_ctrl
   import ftcan_pkg::*;
#(
   parameter bit RX_WAKE_REPORT = 1'b1,
   parameter int TX_STUCK_LIMIT = TX_STUCK_TICKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] chip_mode,
   input wire logic txd,
   input wire logic diff_rx,
   input wire logic high_se_rx,
   input wire logic low_se_rx,
   input wire logic wake_cmp_dom,
   input wire logic high_short_supply,
   input wire logic low_short_fail,
   input wire logic high_open,
   input wire logic low_open,
   output logic high_drv_en,
   output logic low_drv_en,
   output logic high_term_en,
   output logic low_term_en,
   output logic low_line_vbat_sw,
   output logic rxd,
   output logic normal_request,
   output logic wake_irq
);
   logic [1:0] mode_sel_r;
   logic tx_stuck_r;
   logic wake_seen_r;
   logic wake_filt_d_r;
   logic tick;
   logic stuck_done;
   logic recover_done;
   logic wake_filt;
   logic low_power;
   logic [1:0] eff_mode;
   logic tx_path_on;
   logic dominant;
   logic wake_rise;
   logic wr_en;
   logic setup;
   logic addr_ok;
   logic [31:0] rd_mux;

   us_tick_divider #(.DIV(TICK_CYCLES)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   // Permanent dominant watch on the transmit input
   level_persist_timer #(.W(16), .LIMIT(TX_STUCK_LIMIT)) u_stuck (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .level(!txd),
      .done(stuck_done)
   );

   // Recessive time needed before the stuck flag clears
   level_persist_timer #(.W(8), .LIMIT(TX_RECOVER_TICKS)) u_recover (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .level(txd),
      .done(recover_done)
   );

   // Wake comparator filter, only armed in battery-terminated mode
   level_persist_timer #(.W(8), .LIMIT(WAKE_FILTER_TICKS)) u_wake (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .level(wake_cmp_dom && eff_mode == battery_terminated_mode),
      .done(wake_filt)
   );

   // Effective mode and transmit conditions
   assign low_power = chip_mode == chip_sleep || chip_mode == chip_stop;
   assign eff_mode = low_power ? battery_terminated_mode
      : mode_sel_r;
   assign dominant = !txd;
   assign tx_path_on = eff_mode == transmit_receive_mode
      && !tx_stuck_r;
   assign wake_rise = wake_filt && !wake_filt_d_r;

   // APB decode
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite && !pslverr;
   assign addr_ok = paddr == MAIN_CONTROL_OFS
      || paddr == RECEIVER_CONTROL_OFS || paddr == STATUS_OFS;

   // Read data selection
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         MAIN_CONTROL_OFS: rd_mux[MODE_LSB +: 2] = mode_sel_r;
         RECEIVER_CONTROL_OFS: begin
            rd_mux[TX_STUCK_BIT] = tx_stuck_r;
            rd_mux[HIGH_FAIL_BIT] = high_short_supply;
            rd_mux[LOW_FAIL_BIT] = low_short_fail;
            rd_mux[HIGH_OPEN_BIT] = high_open;
            rd_mux[LOW_OPEN_BIT] = low_open;
         end
         STATUS_OFS: begin
            rd_mux[WAKE_SEEN_BIT] = wake_seen_r;
            rd_mux[EFF_MODE_LSB +: 2] = eff_mode;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus answer: ready in the access cycle, data captured in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !addr_ok;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // Interface mode select, code 11 ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sel_r <= MODE_RESET;
      end else if (wr_en && paddr == MAIN_CONTROL_OFS
            && pwdata[MODE_LSB +: 2] != 2'b11) begin
         mode_sel_r <= pwdata[MODE_LSB +: 2];
      end
   end

   // Transmit stuck flag, set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_stuck_r <= 1'b0;
      end else if (stuck_done) begin
         tx_stuck_r <= 1'b1;
      end else if (recover_done) begin
         tx_stuck_r <= 1'b0;
      end
   end

   // Sticky wake seen, write one clears, new wake wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_seen_r <= 1'b0;
         wake_filt_d_r <= 1'b0;
      end else begin
         wake_filt_d_r <= wake_filt;
         if (wake_rise) begin
            wake_seen_r <= 1'b1;
         end else if (wr_en && paddr == STATUS_OFS
               && pwdata[WAKE_SEEN_BIT]) begin
            wake_seen_r <= 1'b0;
         end
      end
   end

   // Line drivers and terminations
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_drv_en <= 1'b0;
         low_drv_en <= 1'b0;
         high_term_en <= 1'b0;
         low_term_en <= 1'b0;
         low_line_vbat_sw <= 1'b0;
      end else begin
         high_drv_en <= tx_path_on && dominant
            && !high_short_supply;
         low_drv_en <= tx_path_on && dominant
            && !low_short_fail;
         high_term_en <= !high_short_supply;
         low_term_en <= !low_short_fail
            && eff_mode != battery_terminated_mode;
         low_line_vbat_sw <= eff_mode == battery_terminated_mode;
      end
   end

   // Receive output selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd <= 1'b1;
      end else if (eff_mode == battery_terminated_mode) begin
         rxd <= !(RX_WAKE_REPORT && !low_power
            && wake_filt);
      end else if (high_short_supply) begin
         rxd <= low_se_rx;
      end else if (low_short_fail) begin
         rxd <= high_se_rx;
      end else begin
         rxd <= diff_rx;
      end
   end

   // Wake-up requests toward the mode controller
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         normal_request <= 1'b0;
         wake_irq <= 1'b0;
      end else begin
         normal_request <= wake_rise && low_power;
         wake_irq <= wake_rise && chip_mode == chip_stop;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_RECESSIVE_OFF: assert property (
      txd |=> !high_drv_en && !low_drv_en)
      else $error("driver on while recessive");
   AST_DOMINANT_ON: assert property (
      !txd && eff_mode == transmit_receive_mode && !tx_stuck_r
      && !high_short_supply && !low_short_fail
      |=> high_drv_en && low_drv_en)
      else $error("drivers off while dominant");
   AST_LOWPOWER_TERM: assert property (
      low_power |=> low_line_vbat_sw && !high_drv_en && !low_drv_en)
      else $error("low power without battery termination");
   // Battery termination closes the pull-up and drops low termination
   AST_BATT_TERM: assert property (
      eff_mode == battery_terminated_mode |=> low_line_vbat_sw && !low_term_en)
      else $error("battery termination not applied");
   // Wake report on the receive output outside low power
   AST_WAKE_RX: assert property (
      RX_WAKE_REPORT && eff_mode == battery_terminated_mode && !low_power
      && wake_filt |=> !rxd)
      else $error("wake not reported on rx");
   AST_HIGH_TERM_BACK: assert property (
      !high_short_supply |=> high_term_en)
      else $error("high termination not restored");
   AST_RXONLY_QUIET: assert property (
      eff_mode == receive_only_mode |=> !high_drv_en && !low_drv_en)
      else $error("drive in receive-only");
   AST_HIGH_FAIL: assert property (
      high_short_supply |=> !high_drv_en && !high_term_en)
      else $error("high driver on with short");
   AST_STUCK_OFF: assert property (
      tx_stuck_r |=> !high_drv_en && !low_drv_en)
      else $error("drive while stuck");
   AST_DIFF_RX: assert property (
      eff_mode != battery_terminated_mode && !high_short_supply
      && !low_short_fail |=> rxd == $past(diff_rx))
      else $error("rx not differential");
   AST_SE_RX: assert property (
      eff_mode != battery_terminated_mode && high_short_supply
      |=> rxd == $past(low_se_rx))
      else $error("rx not low single ended");
   AST_SE_RX_HIGH: assert property (
      eff_mode != battery_terminated_mode && !high_short_supply
      && low_short_fail |=> rxd == $past(high_se_rx))
      else $error("rx not high single ended");
   AST_STUCK_SET: assert property (
      stuck_done |=> tx_stuck_r)
      else $error("stuck flag missed");
   AST_STUCK_CLEAR: assert property (
      recover_done && !stuck_done |=> !tx_stuck_r)
      else $error("stuck flag not cleared");
   AST_WAKE_SLEEP: assert property (
      wake_rise && chip_mode == chip_sleep |=> normal_request && !wake_irq)
      else $error("sleep wake mishandled");
   AST_WAKE_STOP: assert property (
      wake_rise && chip_mode == chip_stop |=> normal_request && wake_irq)
      else $error("stop wake mishandled");
   AST_MODE_WRITE: assert property (
      wr_en && paddr == MAIN_CONTROL_OFS && pwdata[1:0] == 2'b01
      |=> mode_sel_r == 2'b01)
      else $error("mode write lost");
endmodule : fault_tolerant_can_transceiver_ctrl

/* File: logic/ftcan_pkg.sv */
package ftcan_pkg;
   // Interface modes, only three are legal
   typedef enum logic [1:0] {
      transmit_receive_mode = 2'b00,
      receive_only_mode = 2'b01,
      battery_terminated_mode = 2'b10
   } iface_mode_e;
   // Chip global modes, driven by the mode controller outside
   typedef enum logic [1:0] {
      chip_normal = 2'b00,
      chip_standby = 2'b01,
      chip_stop = 2'b10,
      chip_sleep = 2'b11
   } chip_mode_e;
   // Register byte offsets
   localparam logic [7:0] MAIN_CONTROL_OFS = 8'h00;
   localparam logic [7:0] RECEIVER_CONTROL_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   // Field positions
   localparam int MODE_LSB = 0;
   localparam int TX_STUCK_BIT = 1;
   localparam int HIGH_FAIL_BIT = 2;
   localparam int LOW_FAIL_BIT = 3;
   localparam int HIGH_OPEN_BIT = 4;
   localparam int LOW_OPEN_BIT = 5;
   localparam int WAKE_SEEN_BIT = 0;
   localparam int EFF_MODE_LSB = 1;
   // Reset values
   localparam logic [1:0] MODE_RESET = 2'b00;
   // Timing, in its own unit and derived cycle counts
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int TX_STUCK_US = 750;
   localparam int TX_RECOVER_US = 32;
   localparam int WAKE_FILTER_US = 16;
   localparam int TX_STUCK_TICKS = (TX_STUCK_US * 1000) / TICK_NS;
   localparam int TX_RECOVER_TICKS = (TX_RECOVER_US * 1000 + TICK_NS - 1)
      / TICK_NS;
   localparam int WAKE_FILTER_TICKS = (WAKE_FILTER_US * 1000) / TICK_NS;
endpackage : ftcan_pkg

/* File: logic/us_tick_divider.sv */
`timescale 1ns/1ps
// Free running divider, one-cycle enable every DIV cycles
module us_tick_divider #(
   parameter int DIV = 100
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   logic [$clog2(DIV)-1:0] cnt_r;

   // Count down, pulse at wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else if (cnt_r == '0) begin
         cnt_r <= ($clog2(DIV))'(DIV - 1);
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r - 1'b1;
         tick <= 1'b0;
      end
   end
endmodule : us_tick_divider

/* File: logic/level_persist_timer.sv */
`timescale 1ns/1ps
// Raises done once level has held for LIMIT ticks; drops with level
module level_persist_timer #(
   parameter int W = 12,
   parameter int LIMIT = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic level,
   output logic done
);
   logic [W-1:0] cnt_r;

   // Saturating tick counter, restarted whenever level falls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         done <= 1'b0;
      end else if (!level) begin
         cnt_r <= '0;
         done <= 1'b0;
      end else if (tick && cnt_r != W'(LIMIT)) begin
         cnt_r <= cnt_r + 1'b1;
         done <= (cnt_r + 1'b1 == W'(LIMIT));
      end
   end
endmodule : level_persist_timer

/* File: dv/ftcan_bus_model.sv */
`timescale 1ns/1ps
// Two-wire bus with other nodes, seen through the comparators
module ftcan_bus_model (
   input wire logic high_drv_en,
   input wire logic low_drv_en,
   input wire logic other_dom,
   input wire logic high_fail,
   input wire logic low_fail,
   output logic diff_rx,
   output logic high_se_rx,
   output logic low_se_rx,
   output logic wake_cmp_dom
);
   logic dom;
   // Any driver on, or another node, beats recessive
   assign dom = high_drv_en | low_drv_en | other_dom;
   // A failed line reads recessive; the differential view goes wrong
   assign high_se_rx = high_fail | ~dom;
   assign low_se_rx = low_fail | ~dom;
   assign diff_rx = ~(dom ^ (high_fail | low_fail));
   assign wake_cmp_dom = dom;
endmodule : ftcan_bus_model

/* File: dv/test_fault_tolerant_can_transceiver_ctrl.sv */
`timescale 1ns/1ps
module test_fault_tolerant_can_transceiver_ctrl;
   import ftcan_pkg::*;
   localparam int STUCK = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] chip_mode = 2'b00;
   logic txd = 1'b1;
   logic other_dom = 1'b0;
   logic hfail = 1'b0;
   logic lfail = 1'b0;
   logic hopen = 1'b0;
   logic lopen = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, diff_rx, high_se_rx, low_se_rx, wake_cmp_dom;
   logic high_drv_en, low_drv_en, low_line_vbat_sw, rxd;
   logic normal_request, wake_irq;
   logic hterm, lterm;
   int mismatches = 0;
   int n_checks = 0;
   int n;

   always #5 pclk = ~pclk;

   fault_tolerant_can_transceiver_ctrl #(.RX_WAKE_REPORT(1'b1),
      .TX_STUCK_LIMIT(STUCK)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chip_mode(chip_mode), .txd(txd),
      .diff_rx(diff_rx), .high_se_rx(high_se_rx), .low_se_rx(low_se_rx),
      .wake_cmp_dom(wake_cmp_dom), .high_short_supply(hfail),
      .low_short_fail(lfail), .high_open(hopen), .low_open(lopen),
      .high_drv_en(high_drv_en), .low_drv_en(low_drv_en),
      .high_term_en(hterm), .low_term_en(lterm),
      .low_line_vbat_sw(low_line_vbat_sw),
      .rxd(rxd), .normal_request(normal_request), .wake_irq(wake_irq));

   ftcan_bus_model bus (.high_drv_en(high_drv_en), .low_drv_en(low_drv_en),
      .other_dom(other_dom), .high_fail(hfail), .low_fail(lfail),
      .diff_rx(diff_rx), .high_se_rx(high_se_rx), .low_se_rx(low_se_rx),
      .wake_cmp_dom(wake_cmp_dom));

   // Comparisons, counted
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected bit at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected word at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask : cyc
   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   // Reset value, illegal mode, each mode, unmapped place
   task automatic t_regs;
      apb(1'b0, MAIN_CONTROL_OFS, 32'h0);
      chk_word(rd, 32'h0);
      apb(1'b1, MAIN_CONTROL_OFS, 32'h3);
      apb(1'b0, MAIN_CONTROL_OFS, 32'h0);
      chk_word(rd, 32'h0);
      for (int m = 2; m >= 0; m--) begin
         apb(1'b1, MAIN_CONTROL_OFS, 32'(m));
         apb(1'b0, STATUS_OFS, 32'h0);
         chk_word((rd >> EFF_MODE_LSB) & 32'h3, 32'(m));
      end
      apb(1'b0, 8'h0C, 32'h0);
      chk_bit(err, 1'b1);
   endtask : t_regs
   // Dominant and recessive drive, receive-only silence
   task automatic t_drive;
      txd <= 1'b0;
      cyc(3);
      chk_word({high_drv_en, low_drv_en, rxd}, 32'h6);
      txd <= 1'b1;
      other_dom <= 1'b1;
      cyc(2);
      chk_word({high_drv_en, low_drv_en, rxd}, 32'h0);
      other_dom <= 1'b0;
      apb(1'b1, MAIN_CONTROL_OFS, 32'h1);
      txd <= 1'b0;
      other_dom <= 1'b1;
      cyc(2);
      chk_word({high_drv_en, low_drv_en, rxd}, 32'h0);
      txd <= 1'b1;
      other_dom <= 1'b0;
      apb(1'b1, MAIN_CONTROL_OFS, 32'h0);
   endtask : t_drive
   // Line faults: driver off, single-ended report, status, recovery
   task automatic t_fault;
      hfail <= 1'b1;
      hopen <= 1'b1;
      txd <= 1'b0;
      cyc(3);
      chk_word({high_drv_en, low_drv_en, rxd}, 32'h2);
      chk_word({hterm, lterm}, 32'h1);
      apb(1'b0, RECEIVER_CONTROL_OFS, 32'h0);
      chk_word(rd & 32'h3C, 32'h14);
      hfail <= 1'b0;
      hopen <= 1'b0;
      lfail <= 1'b1;
      lopen <= 1'b1;
      cyc(2);
      chk_word({high_drv_en, low_drv_en, rxd}, 32'h4);
      chk_word({hterm, lterm}, 32'h2);
      apb(1'b0, RECEIVER_CONTROL_OFS, 32'h0);
      chk_word(rd & 32'h3C, 32'h28);
      lfail <= 1'b0;
      lopen <= 1'b0;
      cyc(2);
      chk_word({high_drv_en, low_drv_en}, 32'h3);
      chk_word({hterm, lterm}, 32'h3);
      txd <= 1'b1;
   endtask : t_fault
   // Stuck transmit input and its recovery
   task automatic t_stuck;
      txd <= 1'b0;
      n = 0;
      cyc(2);
      while (low_drv_en === 1'b1 && n < (STUCK + 2) * TICK_CYCLES) begin
         n++;
         cyc(1);
      end
      chk_bit(n >= (STUCK - 2) * TICK_CYCLES, 1'b1);
      chk_word({high_drv_en, low_drv_en}, 32'h0);
      apb(1'b0, RECEIVER_CONTROL_OFS, 32'h0);
      chk_word(rd & 32'h2, 32'h2);
      txd <= 1'b1;
      cyc(30 * TICK_CYCLES);
      apb(1'b0, RECEIVER_CONTROL_OFS, 32'h0);
      chk_word(rd & 32'h2, 32'h2);
      cyc(5 * TICK_CYCLES);
      apb(1'b0, RECEIVER_CONTROL_OFS, 32'h0);
      chk_word(rd & 32'h2, 32'h0);
   endtask : t_stuck
   // Bus wake after the filter, in one low-power mode
   task automatic t_wake(input logic [1:0] cm, input logic irq);
      chip_mode <= cm;
      txd <= 1'b0;
      cyc(2);
      chk_word({high_drv_en, low_drv_en, low_line_vbat_sw, rxd}, 32'h3);
      txd <= 1'b1;
      other_dom <= 1'b1;
      n = 0;
      while (normal_request !== 1'b1 && n < 20 * TICK_CYCLES) begin
         n++;
         cyc(1);
      end
      chk_bit(n >= 14 * TICK_CYCLES, 1'b1);
      chk_word({normal_request, wake_irq}, {30'h0, 1'b1, irq});
      cyc(1);
      chk_word({normal_request, wake_irq}, 32'h0);
      other_dom <= 1'b0;
      cyc(4);
   endtask : t_wake
   task automatic t_low_power;
      apb(1'b1, MAIN_CONTROL_OFS, 32'h1);
      t_wake(chip_sleep, 1'b0);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk_word((rd >> EFF_MODE_LSB) & 32'h3, 32'h2);
      chk_word(rd & 32'h1, 32'h1);
      t_wake(chip_stop, 1'b1);
      chip_mode <= chip_normal;
      cyc(2);
      apb(1'b1, STATUS_OFS, 32'h1);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk_word(rd & 32'h7, 32'h2);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk_word((rd >> EFF_MODE_LSB) & 32'h3, 32'h1);
      apb(1'b1, MAIN_CONTROL_OFS, 32'h2);
      other_dom <= 1'b1;
      cyc(14 * TICK_CYCLES);
      chk_bit(rxd, 1'b1);
      cyc(4 * TICK_CYCLES);
      chk_bit(rxd, 1'b0);
      other_dom <= 1'b0;
      cyc(3);
      chk_bit(rxd, 1'b1);
   endtask : t_low_power

   // Watchdog against a hang
   initial begin
      #500000;
      mismatches++;
      stop_test();
   end
   initial begin
      cyc(3);
      chk_bit(rxd, 1'b1);
      presetn <= 1'b1;
      t_regs();
      t_drive();
      t_fault();
      t_stuck();
      t_low_power();
      stop_test();
   end
endmodule : test_fault_tolerant_can_transceiver_ctrl
